// File: hdl/dpdt_defs.vh
// Purpose: shared constants of the dual prescaled down timer
// Assumes: included by bare name from the design file
// Notes: register index times four gives the byte address
`ifndef DPDT_DEFS_VH
`define DPDT_DEFS_VH

// register indices, byte address is index * 4
`define DPDT_IDX_PSC1 10'h0D2
`define DPDT_IDX_TCR1 10'h0D3
`define DPDT_IDX_CTL1 10'h0D4
`define DPDT_IDX_PSC2 10'h0D5
`define DPDT_IDX_TCR2 10'h0D6
`define DPDT_IDX_CTL2 10'h0D7

// control/status field positions
`define DPDT_BIT_ZERO 7
`define DPDT_BIT_IRQEN 6
`define DPDT_BIT_DIR 5
`define DPDT_BIT_LEVEL 4
`define DPDT_BIT_RUN 3
`define DPDT_TAP_HI 2
`define DPDT_TAP_LO 0

// reset values
`define DPDT_RST_CNT 8'hFF
`define DPDT_RST_PSC 7'h7F
`define DPDT_RST_CTL 8'h00

// internal clock division for the prescaler source
`define DPDT_DIV_RATIO 12
`define DPDT_DIV_LAST 4'hB

// bus answers
`define DPDT_RESP_OKAY 2'b00
`define DPDT_RESP_SLVERR 2'b10

`endif

// File: hdl/dpdt_top.v
// Purpose: two prescaled 8-bit down timers behind an AXI4-Lite slave
// Assumes: MCLK is the internal core clock, RST synchronous active high
// Notes: unit 1 owns the external timer pin, unit 2 has none
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "dpdt_defs.vh"

module dpdt_unit #(
  parameter HAS_PIN = 1
) (
  input wire clk,
  input wire rst,
  input wire div_tick,
  input wire pin_level_s,
  input wire pin_rise_s,
  input wire wr_psc,
  input wire wr_cnt,
  input wire wr_ctl,
  input wire [7:0] wdata,
  output wire [7:0] psc_rd,
  output wire [7:0] cnt_rd,
  output wire [7:0] ctl_rd,
  output wire irq,
  output wire pin_out,
  output wire pin_drive
);
  reg [6:0] psc_q;
  reg [6:0] psc_d;
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;
  reg [6:0] ctl_q;
  reg [6:0] ctl_d;
  reg zero_q;
  reg zero_d;
  reg zero_prev_q;
  reg pin_q;
  reg src_tick;
  reg cnt_strobe;
  reg zero_set;
  wire run;
  wire dir;
  wire level;
  wire [2:0] tap;
  wire [6:0] psc_dec;

  assign run = ctl_q[`DPDT_BIT_RUN];
  assign dir = (HAS_PIN != 0) && ctl_q[`DPDT_BIT_DIR];
  assign level = ctl_q[`DPDT_BIT_LEVEL];
  assign tap = ctl_q[`DPDT_TAP_HI:`DPDT_TAP_LO];
  assign psc_dec = psc_q - 7'h01;

  // prescaler source selection
  always @* begin
    if (HAS_PIN == 0 || dir) begin
      src_tick = div_tick;
    end else if (level) begin
      src_tick = div_tick & pin_level_s;
    end else begin
      src_tick = pin_rise_s;
    end
  end

  // counter strobe from the selected prescaler tap
  always @* begin
    cnt_strobe = 1'b0;
    if (run && src_tick) begin
      if (tap == 3'h0) begin
        cnt_strobe = 1'b1;
      end else if (!wr_psc) begin
        // rising edge of tap bit as the prescaler counts down
        cnt_strobe = !psc_q[tap - 3'h1] && psc_dec[tap - 3'h1];
      end
    end
  end

  always @* begin
    if (!run) begin
      psc_d = `DPDT_RST_PSC;
    end else if (wr_psc) begin
      psc_d = wdata[6:0];
    end else if (src_tick) begin
      psc_d = psc_dec;
    end else begin
      psc_d = psc_q;
    end
  end

  always @* begin
    if (wr_cnt) begin
      cnt_d = wdata;
    end else if (cnt_strobe) begin
      cnt_d = cnt_q - 8'h01;
    end else begin
      cnt_d = cnt_q;
    end
  end

  always @* begin
    zero_set = 1'b0;
    if (cnt_strobe && !wr_cnt && cnt_q == 8'h01) begin
      zero_set = 1'b1;
    end
    if (wr_cnt && wdata == 8'h00) begin
      zero_set = 1'b1;
    end
    if (wr_ctl && wdata[`DPDT_BIT_ZERO]) begin
      zero_set = 1'b1;
    end
    if (zero_set) begin
      zero_d = 1'b1;
    end else if (wr_ctl) begin
      zero_d = 1'b0;
    end else begin
      zero_d = zero_q;
    end
  end

  always @* begin
    if (wr_ctl) begin
      ctl_d = wdata[6:0];
    end else begin
      ctl_d = ctl_q;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      psc_q <= `DPDT_RST_PSC;
      cnt_q <= `DPDT_RST_CNT;
      ctl_q <= 7'h00;
      zero_q <= 1'b0;
      zero_prev_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      psc_q <= psc_d;
      cnt_q <= cnt_d;
      ctl_q <= ctl_d;
      zero_q <= zero_d;
      zero_prev_q <= zero_q;
      if (zero_q && !zero_prev_q) begin
        pin_q <= level;
      end
    end
  end

  assign psc_rd = {1'b0, psc_q};
  assign cnt_rd = cnt_q;
  assign ctl_rd = {zero_q, ctl_q};
  assign irq = zero_q & ctl_q[`DPDT_BIT_IRQEN];
  assign pin_out = pin_q;
  assign pin_drive = dir;
endmodule

module dpdt_top (
  input wire MCLK,
  input wire RST,
  input wire [11:0] AWADDR,
  input wire AWVALID,
  output wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output wire WREADY,
  output wire [1:0] BRESP,
  output wire BVALID,
  input wire BREADY,
  input wire [11:0] ARADDR,
  input wire ARVALID,
  output wire ARREADY,
  output wire [31:0] RDATA,
  output wire [1:0] RRESP,
  output wire RVALID,
  input wire RREADY,
  input wire TIMER_PIN_I,
  output wire TIMER_PIN_O,
  output wire TIMER_PIN_OE_N,
  output wire IRQ1,
  output wire IRQ2,
  output wire WAKEUP
);
  reg [3:0] div_q;
  reg div_tick_q;
  reg pin_s1_q;
  reg pin_s2_q;
  reg pin_s3_q;
  reg aw_ok_q;
  reg [9:0] aw_idx_q;
  reg aw_bad_q;
  reg w_ok_q;
  reg [7:0] w_data_q;
  reg w_lane_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [7:0] rdata_q;
  reg [1:0] rresp_q;
  reg [7:0] rd_mux;
  reg rd_hit;
  wire wr_en;
  wire wr_go;
  wire wr_hit;
  wire [9:0] ar_idx;
  wire [7:0] psc1;
  wire [7:0] cnt1;
  wire [7:0] ctl1;
  wire [7:0] psc2;
  wire [7:0] cnt2;
  wire [7:0] ctl2;
  wire pin_out1;
  wire pin_drive1;

  // core clock divided by twelve, one-cycle enable
  always @(posedge MCLK) begin
    if (RST) begin
      div_q <= 4'h0;
      div_tick_q <= 1'b0;
    end else begin
      div_tick_q <= (div_q == `DPDT_DIV_LAST);
      if (div_q == `DPDT_DIV_LAST) begin
        div_q <= 4'h0;
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  // timer pin synchroniser and edge detect
  always @(posedge MCLK) begin
    if (RST) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= TIMER_PIN_I;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // write channel: address and data taken in either order
  assign AWREADY = !aw_ok_q && !bvalid_q;
  assign WREADY = !w_ok_q && !bvalid_q;
  assign wr_go = aw_ok_q && w_ok_q && !bvalid_q;
  assign wr_hit = wr_go && !aw_bad_q;
  assign wr_en = wr_hit && w_lane_q;

  always @(posedge MCLK) begin
    if (RST) begin
      aw_ok_q <= 1'b0;
      aw_idx_q <= 10'h000;
      aw_bad_q <= 1'b0;
      w_ok_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `DPDT_RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_ok_q <= 1'b1;
        aw_idx_q <= AWADDR[11:2];
        aw_bad_q <= (AWADDR[1:0] != 2'b00) ||
                    (AWADDR[11:2] < `DPDT_IDX_PSC1) ||
                    (AWADDR[11:2] > `DPDT_IDX_CTL2);
      end
      if (WVALID && WREADY) begin
        w_ok_q <= 1'b1;
        w_data_q <= WDATA[7:0];
        w_lane_q <= WSTRB[0];
      end
      if (wr_go) begin
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= aw_bad_q ? `DPDT_RESP_SLVERR : `DPDT_RESP_OKAY;
      end else if (bvalid_q && BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;

  // read channel
  assign ARREADY = !rvalid_q;
  assign ar_idx = ARADDR[11:2];

  always @* begin
    rd_hit = (ARADDR[1:0] == 2'b00);
    rd_mux = 8'h00;
    case (ar_idx)
      `DPDT_IDX_PSC1: rd_mux = psc1;
      `DPDT_IDX_TCR1: rd_mux = cnt1;
      `DPDT_IDX_CTL1: rd_mux = ctl1;
      `DPDT_IDX_PSC2: rd_mux = psc2;
      `DPDT_IDX_TCR2: rd_mux = cnt2;
      `DPDT_IDX_CTL2: rd_mux = ctl2;
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge MCLK) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= `DPDT_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_hit ? rd_mux : 8'h00;
      rresp_q <= rd_hit ? `DPDT_RESP_OKAY : `DPDT_RESP_SLVERR;
    end else if (rvalid_q && RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign RVALID = rvalid_q;
  assign RDATA = {24'h00_0000, rdata_q};
  assign RRESP = rresp_q;

  dpdt_unit #(
    .HAS_PIN(1)
  ) u_unit1 (
    .clk(MCLK),
    .rst(RST),
    .div_tick(div_tick_q),
    .pin_level_s(pin_s2_q),
    .pin_rise_s(pin_s2_q & ~pin_s3_q),
    .wr_psc(wr_en && aw_idx_q == `DPDT_IDX_PSC1),
    .wr_cnt(wr_en && aw_idx_q == `DPDT_IDX_TCR1),
    .wr_ctl(wr_en && aw_idx_q == `DPDT_IDX_CTL1),
    .wdata(w_data_q),
    .psc_rd(psc1),
    .cnt_rd(cnt1),
    .ctl_rd(ctl1),
    .irq(IRQ1),
    .pin_out(pin_out1),
    .pin_drive(pin_drive1)
  );

  dpdt_unit #(
    .HAS_PIN(0)
  ) u_unit2 (
    .clk(MCLK),
    .rst(RST),
    .div_tick(div_tick_q),
    .pin_level_s(1'b0),
    .pin_rise_s(1'b0),
    .wr_psc(wr_en && aw_idx_q == `DPDT_IDX_PSC2),
    .wr_cnt(wr_en && aw_idx_q == `DPDT_IDX_TCR2),
    .wr_ctl(wr_en && aw_idx_q == `DPDT_IDX_CTL2),
    .wdata(w_data_q),
    .psc_rd(psc2),
    .cnt_rd(cnt2),
    .ctl_rd(ctl2),
    .irq(IRQ2),
    .pin_out(),
    .pin_drive()
  );

  assign TIMER_PIN_O = pin_out1;
  assign TIMER_PIN_OE_N = !pin_drive1;
  assign WAKEUP = IRQ1 | IRQ2;
endmodule

// File: bench/dpdt_top_props.sv
// Purpose: port checks for the dual prescaled down timer
// Assumes: bound to dpdt_top, single clock MCLK
// Notes: helper regs keep the last address and data taken
`timescale 1ns/10ps
module dpdt_top_props (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic TIMER_PIN_OE_N,
  input wire logic IRQ1,
  input wire logic IRQ2,
  input wire logic WAKEUP
);
  logic [11:0] aw_q, ar_q;
  logic [7:0] w_q;
  logic ws_q;
  wire mapped = aw_q[1:0] == 2'b00 && aw_q >= 12'h348 && aw_q <= 12'h35C;
  always @(posedge MCLK) begin
    if (AWVALID && AWREADY) aw_q <= AWADDR;
    if (WVALID && WREADY) w_q <= WDATA[7:0];
    if (WVALID && WREADY) ws_q <= WSTRB[0];
    if (ARVALID && ARREADY) ar_q <= ARADDR;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence wr_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence rd_taken;
    ARVALID && ARREADY;
  endsequence
  chk_wake_or: assert property (WAKEUP == (IRQ1 || IRQ2))
    else $error("wake-up differs from the two requests");
  chk_wr_answer: assert property (wr_taken |-> ##2 BVALID)
    else $error("write answer late");
  chk_rd_answer: assert property (rd_taken |=> RVALID)
    else $error("read answer late");
  chk_b_stands: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write answer dropped");
  chk_r_stands: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read answer dropped");
  chk_busy_refuse: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while answer pending");
  chk_psc_top: assert property (RVALID && ar_q == 12'h348 |-> RDATA[31:7] == 0)
    else $error("prescaler read high bits set");
  chk_dir_pin: assert property ($rose(BVALID) && aw_q == 12'h350 && ws_q && BRESP == 2'b00
    |-> TIMER_PIN_OE_N == !w_q[5])
    else $error("pin enable ignores direction bit");
  chk_bad_addr: assert property ($rose(BVALID) && !mapped |-> BRESP == 2'b10)
    else $error("unmapped write not refused");
endmodule

// File: bench/test_dual_prescaled_down_timer.sv
// Purpose: self-checking bench for the dual prescaled down timer
// Assumes: bus tasks start and end just after a rising edge
// Notes: reset-value reads first, then row table, then hand-written timer cases
`timescale 1ns/10ps
`include "dpdt_defs.vh"
module test_dual_prescaled_down_timer;
  localparam logic [11:0] psc1_a = {`DPDT_IDX_PSC1, 2'b00};
  localparam logic [11:0] tcr1_a = {`DPDT_IDX_TCR1, 2'b00};
  localparam logic [11:0] ctl1_a = {`DPDT_IDX_CTL1, 2'b00};
  localparam logic [11:0] tcr2_a = {`DPDT_IDX_TCR2, 2'b00};
  localparam logic [11:0] ctl2_a = {`DPDT_IDX_CTL2, 2'b00};
  typedef struct {logic [11:0] a; logic [7:0] d, x; logic [1:0] e;} dpdt_row_t;
  dpdt_row_t rows [7] = '{'{ctl1_a, 8'h07, 8'h07, 2'b00}, '{tcr1_a, 8'h5A, 8'h5A, 2'b00},
    '{psc1_a, 8'h33, 8'h7F, 2'b00}, '{ctl2_a, 8'h36, 8'h36, 2'b00},
    '{tcr2_a, 8'hA5, 8'hA5, 2'b00}, '{12'h360, 8'h11, 8'h00, 2'b10},
    '{12'h349, 8'h11, 8'h00, 2'b10}};
  logic [7:0] rst_v [6] = '{8'h7F, 8'hFF, 8'h00, 8'h7F, 8'hFF, 8'h00};
  logic MCLK = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic TIMER_PIN_I = 0;
  logic [11:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, q;
  logic [3:0] WSTRB = 0;
  logic [1:0] r;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, TIMER_PIN_O, TIMER_PIN_OE_N, IRQ1, IRQ2;
  wire WAKEUP;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  int fail_count = 0, checks_done = 0, cyc = 0;
  dpdt_top dut (.MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .TIMER_PIN_I(TIMER_PIN_I), .TIMER_PIN_O(TIMER_PIN_O), .TIMER_PIN_OE_N(TIMER_PIN_OE_N),
    .IRQ1(IRQ1), .IRQ2(IRQ2), .WAKEUP(WAKEUP));
  always #2.5 MCLK = ~MCLK;
  task give_verdict;
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task ck(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] rs);
    bit aw, w, b, bv;
    @(posedge MCLK);
    {aw, w, b, bv} = 4'b1110;
    AWADDR <= a;
    WDATA <= {24'h0, d};
    WSTRB <= 4'h1;
    AWVALID <= 1;
    WVALID <= 1;
    while (b) begin
      @(negedge MCLK);
      if (AWREADY) aw = 0;
      if (WREADY) w = 0;
      if (BVALID && BREADY) rs = BRESP;
      if (BVALID && BREADY) b = 0;
      bv = BVALID;
      @(posedge MCLK);
      AWVALID <= aw;
      WVALID <= w;
      BREADY <= b && bv;
    end
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    bit ar, rv, seen;
    @(posedge MCLK);
    {ar, rv, seen} = 3'b110;
    ARADDR <= a;
    ARVALID <= 1;
    while (rv) begin
      @(negedge MCLK);
      if (ARREADY) ar = 0;
      if (RVALID && RREADY) {d, rs} = {RDATA, RRESP};
      if (RVALID && RREADY) rv = 0;
      seen = RVALID;
      @(posedge MCLK);
      ARVALID <= ar;
      RREADY <= rv && seen;
    end
  endtask
  // pin view: out level, enable, request 1, wake-up
  task ckp(input logic [3:0] e);
    @(negedge MCLK);
    ck({28'h0, TIMER_PIN_O, TIMER_PIN_OE_N, IRQ1, WAKEUP}, {28'h0, e});
    @(posedge MCLK);
  endtask
  task wait_irq(input bit two, input int lim);
    int k;
    k = 0;
    @(negedge MCLK);
    while (!(two ? IRQ2 : IRQ1) && k < lim) begin
      @(negedge MCLK);
      k++;
    end
    ck({31'h0, two ? IRQ2 : IRQ1}, 1);
    @(posedge MCLK);
  endtask
  initial begin
    repeat (16) @(posedge MCLK);
    RST <= 0;
    @(posedge MCLK);
    for (int i = 0; i < 6; i++) begin
      rd(psc1_a + 12'(4 * i), q, r);
      ck(q, {24'h0, rst_v[i]});
    end
    ckp(4'b0100);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, r);
      ck({30'h0, r}, {30'h0, rows[i].e});
      rd(rows[i].a, q, r);
      ck(q, {24'h0, rows[i].x});
      ck({30'h0, r}, {30'h0, rows[i].e});
    end
    wr(ctl1_a, 8'h40, r);
    wr(tcr1_a, 8'h00, r);
    ckp(4'b0111);
    wr(ctl1_a, 8'h40, r);
    ckp(4'b0100);
    wr(ctl1_a, 8'hC0, r);
    ckp(4'b0111);
    wr(tcr1_a, 8'h02, r);
    wr(ctl1_a, 8'h78, r);
    ckp(4'b0000);
    wait_irq(0, 100);
    repeat (4) @(posedge MCLK);
    ckp(4'b1011);
    rd(psc1_a, q, r);
    ck(q & 32'hFFFF_FF80, 0);
    wr(psc1_a, 8'h05, r);
    rd(psc1_a, q, r);
    ck({31'h0, q inside {4, 5}}, 1);
    repeat (30) @(posedge MCLK);
    rd(ctl1_a, q, r);
    ck(q, 32'hF8);
    rd(tcr1_a, q, r);
    ck(q[7:4], 4'hF);
    wr(tcr2_a, 8'h01, r);
    wr(ctl2_a, 8'h49, r);
    wait_irq(1, 40);
    wr(ctl1_a, 8'h58, r);
    wr(tcr1_a, 8'h03, r);
    repeat (60) @(posedge MCLK);
    rd(tcr1_a, q, r);
    ck(q, 32'h03);
    TIMER_PIN_I <= 1;
    wait_irq(0, 100);
    TIMER_PIN_I <= 0;
    wr(ctl1_a, 8'h48, r);
    wr(tcr1_a, 8'h02, r);
    for (int k = 1; k <= 2; k++) begin
      repeat (6) @(posedge MCLK);
      TIMER_PIN_I <= 1;
      repeat (6) @(posedge MCLK);
      TIMER_PIN_I <= 0;
      rd(tcr1_a, q, r);
      ck(q, 32'(2 - k));
    end
    wait_irq(0, 4);
    RST <= 1;
    repeat (16) @(posedge MCLK);
    RST <= 0;
    @(posedge MCLK);
    ckp(4'b0100);
    rd(tcr1_a, q, r);
    ck(q, 32'hFF);
    give_verdict();
  end
endmodule
bind dpdt_top dpdt_top_props u_props (.MCLK(MCLK), .RST(RST), .AWADDR(AWADDR),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
  .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
  .TIMER_PIN_OE_N(TIMER_PIN_OE_N), .IRQ1(IRQ1), .IRQ2(IRQ2), .WAKEUP(WAKEUP));
